// ===== line_rx_decoder_status_counters.sv
// receive line decoder status, event latches, interrupt and error counters
//
// Behaviour
// - zero-run status bit means count nonzero
// - violation status bit means count nonzero
// - loss status bit follows live loss condition
// - signature latch sets on three/four-zero signature
// - zero-run event latch sets on event
// - zero-run count latch sets on status rise
// - violation latch sets on violation, or code violation
// - violation count latch sets on status rise
// - loss change latch sets on either edge
// - decode disabled holds loss cleared
// - enabled latches raise irq under port enable
// - sixteen-bit bipolar violation count
// - sixteen-bit excessive zero count
// - counts visible only after update strobe
// - decode-disable selects plain mark-inversion decoding
// - code-violation option only in E3 mode
//
// The APB register port was left to the implementer.
`include "line_rx_cfg.svh"
`default_nettype none

module line_rx_decoder_status_counters (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic los_detect,
  input wire logic e3_mode,
  input wire line_rx_pkg::line_events_t line_events,
  input wire logic perf_monitor_update,
  output logic substitution_decode_disable,
  output logic irq
);

  function automatic logic [15:0] sat_add(input logic [15:0] acc,
                                          input logic ev);
    if (acc == `LRX_CNT_MAX) begin
      sat_add = acc;
    end else begin
      sat_add = acc + {15'h0000, ev};
    end
  endfunction : sat_add

  line_rx_pkg::ctrl_t ctrl_r, ctrl_nxt;
  logic [5:0] ie_r, ie_nxt;
  logic [5:0] latch_r, latch_nxt;
  logic [15:0] viol_acc_r, viol_acc_nxt;
  logic [15:0] zero_acc_r, zero_acc_nxt;
  logic [15:0] violation_count_value, viol_cnt_nxt;
  logic [15:0] zero_run_count_value, zero_cnt_nxt;
  logic loss_prev_r;
  logic viol_nz_prev_r;
  logic zero_nz_prev_r;
  logic [31:0] prdata_r, prdata_nxt;
  logic slverr_r, slverr_nxt;
  logic valid_r, valid_nxt;

  logic [9:0] idx;
  logic hit;
  logic wr_done;
  logic loss_now;
  logic violation_count_nonzero;
  logic zero_run_count_nonzero;
  logic viol_event;
  logic [5:0] set_bits;
  logic [5:0] clr_bits;
  logic [15:0] live_word;

  assign idx = paddr[11:2];
  assign wr_done = psel & penable & valid_r & ce & pwrite;

  // the decoder datapath takes this level directly
  assign substitution_decode_disable =
    ctrl_r.substitution_decode_disable;

  // loss cannot be seen while substitution decoding is off
  assign loss_now = los_detect
                    & ~ctrl_r.substitution_decode_disable;

  // status follows the readable counts, so it also changes on the strobe
  assign violation_count_nonzero =
    (violation_count_value != `LRX_CNT_RST);
  assign zero_run_count_nonzero =
    (zero_run_count_value != `LRX_CNT_RST);

  // option has no meaning for three-zero substitution lines
  assign viol_event = (ctrl_r.code_violation_count_select & e3_mode)
                      ? line_events.code_violation
                      : line_events.bipolar_violation;

  always_comb begin
    live_word = 16'h0000;
    live_word[`LRX_LIVE_LOSS] = loss_now;
    live_word[`LRX_LIVE_VIOL_NZ] = violation_count_nonzero;
    live_word[`LRX_LIVE_ZERO_NZ] = zero_run_count_nonzero;
  end

  always_comb begin
    hit = 1'b1;
    unique case (idx)
      `LRX_IDX_CTRL, `LRX_IDX_LIVE, `LRX_IDX_LATCH,
      `LRX_IDX_IE, `LRX_IDX_VIOL_CNT, `LRX_IDX_ZERO_CNT: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end

  // bus slave: data is captured once per transfer, answered next cycle
  always_comb begin
    prdata_nxt = prdata_r;
    slverr_nxt = slverr_r;
    valid_nxt = valid_r;
    if (psel && !valid_r) begin
      valid_nxt = 1'b1;
      slverr_nxt = ~hit;
      prdata_nxt = 32'h0000_0000;
      if (!pwrite) begin
        unique case (idx)
          `LRX_IDX_CTRL: begin
            prdata_nxt[`LRX_CTRL_DECODE_DIS] =
              ctrl_r.substitution_decode_disable;
            prdata_nxt[`LRX_CTRL_CV_SELECT] =
              ctrl_r.code_violation_count_select;
            prdata_nxt[`LRX_CTRL_PORT_IE] = ctrl_r.port_interrupt_enable;
          end
          `LRX_IDX_LIVE: prdata_nxt[15:0] = live_word;
          `LRX_IDX_LATCH: prdata_nxt[5:0] = latch_r;
          `LRX_IDX_IE: prdata_nxt[5:0] = ie_r;
          `LRX_IDX_VIOL_CNT: prdata_nxt[15:0] = violation_count_value;
          `LRX_IDX_ZERO_CNT: prdata_nxt[15:0] = zero_run_count_value;
          default: prdata_nxt = 32'h0000_0000;
        endcase
      end
    end else if (psel && penable && valid_r) begin
      valid_nxt = 1'b0;
    end else if (!psel) begin
      valid_nxt = 1'b0;
    end
  end

  assign prdata = prdata_r;
  assign pslverr = slverr_r & pready;
  assign pready = psel & penable & valid_r & ce;

  // control and enable registers
  always_comb begin
    ctrl_nxt = ctrl_r;
    ie_nxt = ie_r;
    if (wr_done && idx == `LRX_IDX_CTRL) begin
      ctrl_nxt.substitution_decode_disable = pwdata[`LRX_CTRL_DECODE_DIS];
      ctrl_nxt.code_violation_count_select = pwdata[`LRX_CTRL_CV_SELECT];
      ctrl_nxt.port_interrupt_enable = pwdata[`LRX_CTRL_PORT_IE];
    end
    if (wr_done && idx == `LRX_IDX_IE) begin
      ie_nxt = pwdata[5:0];
    end
  end

  // counters
  always_comb begin
    viol_cnt_nxt = violation_count_value;
    zero_cnt_nxt = zero_run_count_value;
    viol_acc_nxt = sat_add(viol_acc_r, viol_event);
    zero_acc_nxt = sat_add(zero_acc_r, line_events.zero_run);
    if (perf_monitor_update) begin
      // event in the strobe cycle still lands in the closing interval
      viol_cnt_nxt = viol_acc_nxt;
      zero_cnt_nxt = zero_acc_nxt;
      viol_acc_nxt = `LRX_CNT_RST;
      zero_acc_nxt = `LRX_CNT_RST;
    end
  end

  // latches
  always_comb begin
    set_bits = 6'h00;
    set_bits[`LRX_BIT_LOSS] = loss_now ^ loss_prev_r;
    set_bits[`LRX_BIT_VIOL_CNT] =
      violation_count_nonzero & ~viol_nz_prev_r;
    set_bits[`LRX_BIT_VIOL_EV] = viol_event;
    set_bits[`LRX_BIT_ZERO_CNT] =
      zero_run_count_nonzero & ~zero_nz_prev_r;
    set_bits[`LRX_BIT_ZERO_EV] = line_events.zero_run;
    set_bits[`LRX_BIT_SIG] =
      line_events.sig_three_zero | line_events.sig_four_zero;
    clr_bits = 6'h00;
    if (wr_done && idx == `LRX_IDX_LATCH) begin
      clr_bits = pwdata[5:0];
    end
    latch_nxt = (latch_r & ~clr_bits) | set_bits;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= `LRX_CTRL_RST;
      ie_r <= `LRX_IE_RST;
      latch_r <= `LRX_LATCH_RST;
      viol_acc_r <= `LRX_CNT_RST;
      zero_acc_r <= `LRX_CNT_RST;
      violation_count_value <= `LRX_CNT_RST;
      zero_run_count_value <= `LRX_CNT_RST;
      loss_prev_r <= 1'b0;
      viol_nz_prev_r <= 1'b0;
      zero_nz_prev_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
      slverr_r <= 1'b0;
      valid_r <= 1'b0;
      irq <= 1'b0;
    end else if (ce) begin
      ctrl_r <= ctrl_nxt;
      ie_r <= ie_nxt;
      latch_r <= latch_nxt;
      viol_acc_r <= viol_acc_nxt;
      zero_acc_r <= zero_acc_nxt;
      violation_count_value <= viol_cnt_nxt;
      zero_run_count_value <= zero_cnt_nxt;
      loss_prev_r <= loss_now;
      viol_nz_prev_r <= violation_count_nonzero;
      zero_nz_prev_r <= zero_run_count_nonzero;
      prdata_r <= prdata_nxt;
      slverr_r <= slverr_nxt;
      valid_r <= valid_nxt;
      // registered so the level never glitches on a bus write
      irq <= ctrl_nxt.port_interrupt_enable
             & (|(latch_nxt & ie_nxt));
    end
  end

endmodule : line_rx_decoder_status_counters

`default_nettype wire

// ===== line_rx_cfg.svh
// register indices, field positions, reset values of the line receive block
`ifndef LINE_RX_CFG_SVH
`define LINE_RX_CFG_SVH

// register indices; byte address is four times the index
`define LRX_IDX_CTRL 10'h090
`define LRX_IDX_LIVE 10'h094
`define LRX_IDX_LATCH 10'h096
`define LRX_IDX_IE 10'h098
`define LRX_IDX_VIOL_CNT 10'h09C
`define LRX_IDX_ZERO_CNT 10'h09E

// control register fields
`define LRX_CTRL_DECODE_DIS 0
`define LRX_CTRL_CV_SELECT 3
`define LRX_CTRL_PORT_IE 8

// live status fields
`define LRX_LIVE_LOSS 0
`define LRX_LIVE_VIOL_NZ 1
`define LRX_LIVE_ZERO_NZ 3

// latch and enable fields, same layout
`define LRX_BIT_LOSS 0
`define LRX_BIT_VIOL_CNT 1
`define LRX_BIT_VIOL_EV 2
`define LRX_BIT_ZERO_CNT 3
`define LRX_BIT_ZERO_EV 4
`define LRX_BIT_SIG 5
`define LRX_NUM_BITS 6

// reset values
`define LRX_CTRL_RST 3'h0
`define LRX_IE_RST 6'h00
`define LRX_LATCH_RST 6'h00
`define LRX_CNT_RST 16'h0000
`define LRX_CNT_MAX 16'hFFFF

`endif

// ===== line_rx_pkg.sv
// types shared by the line receive status block
`default_nettype none

package line_rx_pkg;

  typedef struct packed {
    logic sig_three_zero;
    logic sig_four_zero;
    logic zero_run;
    logic code_violation;
    logic bipolar_violation;
  } line_events_t;

  typedef struct packed {
    logic port_interrupt_enable;
    logic code_violation_count_select;
    logic substitution_decode_disable;
  } ctrl_t;

endpackage : line_rx_pkg

`default_nettype wire

// ===== line_rx_props.sv
// port checker for the line receive status block
`include "line_rx_cfg.svh"
`default_nettype none
module line_rx_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic substitution_decode_disable,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic wr;
  logic rd;
  assign wr = psel && penable && pwrite && pready;
  assign rd = pready && !pwrite;
  property p_ready;
    psel && penable && ce && $past(psel && !penable && ce) |-> pready;
  endproperty
  a_ready: assert property (p_ready) else $error("access not answered");
  property p_idle;
    !psel |-> !pready;
  endproperty
  a_idle: assert property (p_idle) else $error("ready without select");
  property p_err;
    pslverr |-> pready;
  endproperty
  a_err: assert property (p_err) else $error("error outside access");
  property p_hold;
    pready |=> $stable(prdata);
  endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_upper;
    rd |-> prdata[31:16] == 16'h0000;
  endproperty
  a_upper: assert property (p_upper) else $error("upper half set") ;
  property p_sdd_read;
    rd && paddr[11:2] == `LRX_IDX_CTRL |-> prdata[0] == substitution_decode_disable;
  endproperty
  a_sdd_read: assert property (p_sdd_read) else $error("disable pin off");
  property p_sdd_change;
    $changed(substitution_decode_disable) |-> $past(wr) || $past(wr, 2);
  endproperty
  a_sdd_change: assert property (p_sdd_change) else $error("disable moved");
  property p_loss_dis;
    rd && paddr[11:2] == `LRX_IDX_LIVE && substitution_decode_disable &&
      $past(substitution_decode_disable, 2) |-> !prdata[0];
  endproperty
  a_loss_dis: assert property (p_loss_dis) else $error("loss while off");
  property p_irq_fall;
    $fell(irq) |-> $past(wr) || $past(wr, 2);
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("irq fell alone");
  c_err: cover property (pready && pslverr);
  c_irq: cover property ($rose(irq));
  c_sdd: cover property ($rose(substitution_decode_disable));
endmodule : line_rx_props
bind line_rx_decoder_status_counters line_rx_props u_props (.pclk(pclk),
  .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .irq(irq),
  .substitution_decode_disable(substitution_decode_disable));
`default_nettype wire

// ===== line_rx_partner.sv
// behavioural line receiver delivering decoded events and loss
`default_nettype none
module line_rx_partner (
  input wire logic pclk,
  input wire logic [4:0] fire,
  input wire logic loss,
  output line_rx_pkg::line_events_t line_events,
  output logic los_detect
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    line_events = '0;
    los_detect = 1'b0;
  end
  // one clean pulse per commanded event, as the decoder gives them
  always @(posedge pclk) begin
    line_events <= line_rx_pkg::line_events_t'(fire);
    los_detect <= loss;
  end
endmodule : line_rx_partner
`default_nettype wire

// ===== line_rx_decoder_status_counters_bench.sv
// register level bench for the line receive status block
`include "line_rx_cfg.svh"
`default_nettype none
module line_rx_decoder_status_counters_bench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [9:0] x_ctl = `LRX_IDX_CTRL;
  localparam logic [9:0] x_lat = `LRX_IDX_LATCH;
  localparam logic [9:0] x_ie = `LRX_IDX_IE;
  localparam logic [9:0] x_live = `LRX_IDX_LIVE;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic pm_strobe, e3, loss, los, sdd, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [4:0] fire;
  line_rx_pkg::line_events_t evs;
  logic [5:0] ev_bit [5] = '{6'h04, 6'h00, 6'h10, 6'h20, 6'h20};
  int n_fail, n_checks, i;
  line_rx_partner far (.pclk(pclk), .fire(fire), .loss(loss),
    .line_events(evs), .los_detect(los));
  line_rx_decoder_status_counters uut (.pclk(pclk), .presetn(presetn),
    .ce(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .los_detect(los), .e3_mode(e3), .line_events(evs),
    .perf_monitor_update(pm_strobe), .substitution_decode_disable(sdd),
    .irq(irq));
  task finish_test;
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : finish_test
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task apb(input logic w, input logic [9:0] x, input logic [15:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {x, 2'b00};
    pwdata <= {16'h0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    // ready is combinational: look at it mid-cycle, away from the edge
    do begin
      @(negedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      n_fail++;
      finish_test();
    end
    rd = prdata;
    err = pslverr;
    @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task rc(input string nm, input logic [9:0] x, input logic [31:0] e);
    apb(1'b0, x, 16'h0000);
    chk(nm, rd, e);
  endtask : rc
  // pulse lasts one cycle so the block sees exactly one event
  task pulse(input logic [4:0] f, input logic s);
    @(posedge pclk);
    fire <= f;
    pm_strobe <= s;
    @(posedge pclk);
    fire <= 5'h00;
    pm_strobe <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask : pulse
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  initial begin
    {presetn, psel, penable, pwrite, pm_strobe, e3, loss} = 7'h00;
    {paddr, pwdata, fire, n_fail, n_checks} = '0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rc("ie reset", x_ie, 32'h0);
    rc("zero count reset", `LRX_IDX_ZERO_CNT, 32'h0);
    apb(1'b1, x_ctl, 16'h0100);
    apb(1'b1, x_ie, 16'h003F);
    for (i = 0; i < 5; i++) begin
      pulse(5'h01 << i, 1'b0);
      rc("event latch", x_lat, {26'h0, ev_bit[i]});
      chk("irq", {31'h0, irq}, {31'h0, |ev_bit[i]});
      apb(1'b1, x_lat, 16'h003F);
      rc("latch clear", x_lat, 32'h0);
      chk("irq clear", {31'h0, irq}, 32'h0);
    end
    for (i = 0; i < 5; i++) pulse(i < 2 ? 5'h01 : 5'h04, 1'b0);
    rc("count held", `LRX_IDX_VIOL_CNT, 32'h0);
    pulse(5'h00, 1'b1);
    rc("viol count", `LRX_IDX_VIOL_CNT, 32'h3);
    rc("zero count", `LRX_IDX_ZERO_CNT, 32'h4);
    rc("live counts", x_live, 32'hA);
    rc("count latches", x_lat, 32'h1E);
    apb(1'b1, x_lat, 16'h003F);
    pulse(5'h00, 1'b1);
    rc("restart", `LRX_IDX_VIOL_CNT, 32'h0);
    loss <= 1'b1;
    repeat (4) @(posedge pclk);
    rc("live loss", x_live, 32'h1);
    rc("loss latch", x_lat, 32'h1);
    apb(1'b1, x_lat, 16'h003F);
    apb(1'b1, x_ctl, 16'h0101);
    rc("loss off", x_live, 32'h0);
    chk("decode off", {31'h0, sdd}, 32'h1);
    rc("loss drop", x_lat, 32'h1);
    apb(1'b0, 10'h092, 16'h0000);
    chk("unmapped err", {31'h0, err}, 32'h1);
    chk("unmapped data", rd, 32'h0);
    e3 <= 1'b1;
    apb(1'b1, x_ie, 16'h0000);
    apb(1'b1, x_ctl, 16'h0108);
    apb(1'b1, x_lat, 16'h003F);
    pulse(5'h02, 1'b0);
    rc("code violation", x_lat, 32'h4);
    chk("irq masked", {31'h0, irq}, 32'h0);
    finish_test();
  end
endmodule : line_rx_decoder_status_counters_bench
`default_nettype wire
